// >>> tsc_defines.svh
// Constants for the termination and system-enable configuration block
// Overview of operation
// RL1 - Bits 7:5 hold termination code, 12.5 to 170.0 mA, reset code 010
// RL2 - Bit 4 set selects fast-charge current divided by 20, highest priority
// RL3 - Bit 3 set, bit 4 clear, selects fast-charge current divided by 10
// RL4 - Bit 2 set, bits 4 and 3 clear, selects fast-charge current divided by 5
// RL5 - Ratio-derived thresholds are clamped between 12.5 mA and 170 mA
// RL6 - Mode 00 enables system output when regulator active and system voltage present
// RL7 - Mode 01 enables system output from the battery-side node voltage
// RL8 - Mode 10 enables output and disables isolation switch below weak-battery level
// RL9 - Mode 11 enables in regulator mode uncharged, else when node at or above weak
// RL10 - Mode 10 behaviour applies only with input supply at 0 V and monitor enabled
// RL11 - Threshold recomputed whenever this register or fast-charge current is written
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH
`define TSC_CTRL_ADDR 8'h11
`define TSC_CTRL_RESET 8'h40
`define TSC_CODE_MSB 7
`define TSC_CODE_LSB 5
`define TSC_DIV20_BIT 4
`define TSC_DIV10_BIT 3
`define TSC_DIV5_BIT 2
`define TSC_MODE_MSB 1
`define TSC_MODE_LSB 0
`define TSC_THR_MIN 16'h007d
`define TSC_THR_MAX 16'h06a4
`define TSC_CODE0 16'h007d
`define TSC_CODE1 16'h0145
`define TSC_CODE2 16'h020d
`define TSC_CODE3 16'h02d5
`define TSC_CODE4 16'h039d
`define TSC_CODE5 16'h0497
`define TSC_CODE6 16'h0591
`define TSC_CODE7 16'h06a4
`endif

// >>> tsc_pkg.sv
// Types for the termination and system-enable configuration block
package tsc_pkg;
    typedef enum logic [1:0]
    {
        TSC_SYS_REG = 2'b00,
        TSC_SYS_BAT = 2'b01,
        TSC_SYS_WEAK = 2'b10,
        TSC_SYS_CHG = 2'b11
    } tsc_sys_mode_t;
    typedef enum logic [1:0]
    {
        TSC_ST_IDLE = 2'b01,
        TSC_ST_LOAD = 2'b10
    } tsc_calc_state_t;
endpackage : tsc_pkg

// >>> tsc_threshold_calc.sv
// Termination threshold selection with ratio, clamp and registered result
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_threshold_calc
    import tsc_pkg::*;
#(
    parameter int CUR_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic recompute,
    input wire logic [7:0] ctrl,
    input wire logic [CUR_W-1:0] fast_charge_current_dma,
    output logic [CUR_W-1:0] termination_threshold_dma,
    output logic threshold_valid
);
    tsc_calc_state_t state_ff;
    tsc_calc_state_t nxt_state;
    logic [CUR_W-1:0] thr_ff;
    logic [CUR_W-1:0] nxt_thr;
    logic [CUR_W-1:0] code_val;

    function automatic logic [CUR_W-1:0] clamp_cur(input logic [CUR_W-1:0] v);
        if (v < CUR_W'(`TSC_THR_MIN))
            clamp_cur = CUR_W'(`TSC_THR_MIN);
        else if (v > CUR_W'(`TSC_THR_MAX))
            clamp_cur = CUR_W'(`TSC_THR_MAX);
        else
            clamp_cur = v;
    endfunction : clamp_cur

    always_comb
    begin
        case (ctrl[`TSC_CODE_MSB:`TSC_CODE_LSB]) // RL1
            3'h0: code_val = CUR_W'(`TSC_CODE0);
            3'h1: code_val = CUR_W'(`TSC_CODE1);
            3'h2: code_val = CUR_W'(`TSC_CODE2);
            3'h3: code_val = CUR_W'(`TSC_CODE3);
            3'h4: code_val = CUR_W'(`TSC_CODE4);
            3'h5: code_val = CUR_W'(`TSC_CODE5);
            3'h6: code_val = CUR_W'(`TSC_CODE6);
            default: code_val = CUR_W'(`TSC_CODE7);
        endcase
    end

    always_comb
    begin
        if (ctrl[`TSC_DIV20_BIT]) // RL2
            nxt_thr = clamp_cur(CUR_W'(fast_charge_current_dma / 20)); // RL5
        else if (ctrl[`TSC_DIV10_BIT]) // RL3
            nxt_thr = clamp_cur(CUR_W'(fast_charge_current_dma / 10)); // RL5
        else if (ctrl[`TSC_DIV5_BIT]) // RL4
            nxt_thr = clamp_cur(CUR_W'(fast_charge_current_dma / 5)); // RL5
        else
            nxt_thr = code_val;
    end

    always_comb
    begin
        case (state_ff)
            TSC_ST_IDLE: nxt_state = recompute ? TSC_ST_LOAD : TSC_ST_IDLE;
            TSC_ST_LOAD: nxt_state = recompute ? TSC_ST_LOAD : TSC_ST_IDLE;
            default: nxt_state = TSC_ST_LOAD;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_ff <= TSC_ST_LOAD;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            thr_ff <= CUR_W'(`TSC_CODE2);
        else if (state_ff == TSC_ST_LOAD) // RL11
            thr_ff <= nxt_thr;
    end

    assign termination_threshold_dma = thr_ff;
    assign threshold_valid = (state_ff == TSC_ST_IDLE);

    thr_clamp_a: assert property (@(posedge core_clk) disable iff (rst) // RL5
        threshold_valid |-> (thr_ff >= CUR_W'(`TSC_THR_MIN) && thr_ff <= CUR_W'(`TSC_THR_MAX)))
        else $error("Termination threshold out of clamp range");
    div20_prio_a: assert property (@(posedge core_clk) disable iff (rst) // RL2
        (state_ff == TSC_ST_LOAD && ctrl[`TSC_DIV20_BIT])
        |=> thr_ff == clamp_cur(CUR_W'($past(fast_charge_current_dma) / 20)))
        else $error("Divide by 20 not applied");
    div10_sel_a: assert property (@(posedge core_clk) disable iff (rst) // RL3
        (state_ff == TSC_ST_LOAD && !ctrl[`TSC_DIV20_BIT] && ctrl[`TSC_DIV10_BIT])
        |=> thr_ff == clamp_cur(CUR_W'($past(fast_charge_current_dma) / 10)))
        else $error("Divide by 10 not applied");
    div5_sel_a: assert property (@(posedge core_clk) disable iff (rst) // RL4
        (state_ff == TSC_ST_LOAD && ctrl[4:2] == 3'h1)
        |=> thr_ff == clamp_cur(CUR_W'($past(fast_charge_current_dma) / 5)))
        else $error("Divide by 5 not applied");
    code_sel_a: assert property (@(posedge core_clk) disable iff (rst) // RL1
        (state_ff == TSC_ST_LOAD && ctrl[4:2] == 3'h0 && ctrl[7:5] == 3'h7)
        |=> thr_ff == CUR_W'(`TSC_CODE7))
        else $error("Termination code table mismatch");
    recompute_lat_a: assert property (@(posedge core_clk) disable iff (rst) // RL11
        recompute |=> !threshold_valid ##1 1'b1)
        else $error("Recompute did not start a load");
    clamp_hit_c: cover property (@(posedge core_clk) disable iff (rst)
        threshold_valid && thr_ff == CUR_W'(`TSC_THR_MAX));
endmodule : tsc_threshold_calc

// >>> tsc_config.sv
// Termination current and system-enable configuration register
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_config
    import tsc_pkg::*;
#(
    parameter int CUR_W = 16
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [CUR_W-1:0] fast_charge_current_dma,
    input wire logic fast_charge_current_wr,
    input wire logic input_regulator_active,
    input wire logic system_voltage_ok,
    input wire logic battery_side_node_ok,
    input wire logic battery_weak,
    input wire logic charging_enabled,
    input wire logic input_supply_zero,
    input wire logic battery_monitor_enable,
    output logic [CUR_W-1:0] termination_threshold_dma,
    output logic threshold_valid,
    output logic system_enable_output,
    output logic isolation_switch_disable
);
    logic [7:0] ctrl_ff;
    logic [7:0] rdata_ff;
    logic enable_out_ff;
    logic iso_dis_ff;
    logic nxt_enable_out;
    logic nxt_iso_dis;
    logic ctrl_hit;
    logic recompute;
    logic weak_mode_armed;
    tsc_sys_mode_t sys_mode;

    assign ctrl_hit = (reg_addr == `TSC_CTRL_ADDR);
    assign sys_mode = tsc_sys_mode_t'(ctrl_ff[`TSC_MODE_MSB:`TSC_MODE_LSB]);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ctrl_ff <= `TSC_CTRL_RESET;
        else if (reg_wr && ctrl_hit)
            ctrl_ff <= reg_wdata;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            rdata_ff <= 8'h00;
        else if (reg_rd)
            rdata_ff <= ctrl_hit ? ctrl_ff : 8'h00;
    end
    assign reg_rdata = rdata_ff;

    // Write to the register or to the fast-charge current reloads the threshold
    assign recompute = (reg_wr && ctrl_hit) || fast_charge_current_wr; // RL11

    tsc_threshold_calc #(
        .CUR_W(CUR_W)
    ) u_calc (
        .core_clk(core_clk),
        .rst(rst),
        .recompute(recompute),
        .ctrl(ctrl_ff),
        .fast_charge_current_dma(fast_charge_current_dma),
        .termination_threshold_dma(termination_threshold_dma),
        .threshold_valid(threshold_valid)
    );

    assign weak_mode_armed = input_supply_zero && battery_monitor_enable; // RL10

    always_comb
    begin
        nxt_enable_out = 1'b0;
        nxt_iso_dis = 1'b0;
        case (sys_mode)
            TSC_SYS_REG: nxt_enable_out = input_regulator_active && system_voltage_ok; // RL6
            TSC_SYS_BAT: nxt_enable_out = battery_side_node_ok; // RL7
            TSC_SYS_WEAK:
            begin
                if (weak_mode_armed) // RL10
                begin
                    // Both actions follow the weak-battery condition
                    nxt_enable_out = battery_weak; // RL8
                    nxt_iso_dis = battery_weak; // RL8
                end
                else
                    nxt_enable_out = input_regulator_active && system_voltage_ok;
            end
            TSC_SYS_CHG:
                nxt_enable_out = charging_enabled ? battery_side_node_ok : input_regulator_active; // RL9
            default: nxt_enable_out = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            enable_out_ff <= 1'b0;
        else
            enable_out_ff <= nxt_enable_out;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            iso_dis_ff <= 1'b0;
        else
            iso_dis_ff <= nxt_iso_dis;
    end

    assign system_enable_output = enable_out_ff;
    assign isolation_switch_disable = iso_dis_ff;

    mode_reg_a: assert property (@(posedge core_clk) disable iff (rst) // RL6
        (sys_mode == TSC_SYS_REG && !reg_wr) |=>
        system_enable_output == ($past(input_regulator_active) && $past(system_voltage_ok)))
        else $error("Mode 00 system enable wrong");
    mode_bat_a: assert property (@(posedge core_clk) disable iff (rst) // RL7
        (sys_mode == TSC_SYS_BAT && !reg_wr) |=> system_enable_output == $past(battery_side_node_ok))
        else $error("Mode 01 system enable wrong");
    mode_weak_a: assert property (@(posedge core_clk) disable iff (rst) // RL8
        (sys_mode == TSC_SYS_WEAK && weak_mode_armed && !reg_wr) |=>
        system_enable_output == $past(battery_weak)
        && isolation_switch_disable == $past(battery_weak))
        else $error("Mode 10 weak battery handling wrong");
    weak_gate_a: assert property (@(posedge core_clk) disable iff (rst) // RL10
        !weak_mode_armed |=> !isolation_switch_disable)
        else $error("Isolation disabled without supply absent and monitor on");
    mode_chg_a: assert property (@(posedge core_clk) disable iff (rst) // RL9
        (sys_mode == TSC_SYS_CHG && charging_enabled && !reg_wr) |=>
        system_enable_output == $past(battery_side_node_ok))
        else $error("Mode 11 charging enable wrong");
    reg_write_a: assert property (@(posedge core_clk) disable iff (rst) // RL1
        (reg_wr && ctrl_hit) |=> ctrl_ff == $past(reg_wdata) ##2 threshold_valid || reg_wr
        || fast_charge_current_wr || $past(recompute))
        else $error("Register write not taken");
    write_reload_a: assert property (@(posedge core_clk) disable iff (rst) // RL11
        fast_charge_current_wr |=> !threshold_valid)
        else $error("Fast charge write did not reload threshold");
    weak_iso_c: cover property (@(posedge core_clk) disable iff (rst)
        sys_mode == TSC_SYS_WEAK && isolation_switch_disable);
    chg_en_c: cover property (@(posedge core_clk) disable iff (rst)
        sys_mode == TSC_SYS_CHG && system_enable_output);
    rd_hit_c: cover property (@(posedge core_clk) disable iff (rst)
        reg_rd && ctrl_hit ##1 reg_rdata != 8'h00);
endmodule : tsc_config

// >>> tsc_host_model.sv
// Host model driving the register interface of the configuration block
`timescale 1ns/1ps
module tsc_host_model
(
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released bus shows inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        reg_addr = ~a;
    endtask : rd
endmodule : tsc_host_model

// >>> tb.sv
// Self-checking testbench for the configuration block
`timescale 1ns/1ps
module tb;
    import tsc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic reg_wr, reg_rd, fcc_wr = 1'b0, thr_valid, se, iso;
    logic [15:0] cur = 16'h0000, thr;
    logic [6:0] lv = 7'h00;
    logic [31:0] rnd = 32'h6;
    int fail_count = 0;
    int n_tests = 0;
    localparam logic [15:0] CODE_T [8] = '{16'h007d, 16'h0145, 16'h020d, 16'h02d5,
        16'h039d, 16'h0497, 16'h0591, 16'h06a4};
    always #5 core_clk = ~core_clk;
    tsc_host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    tsc_config u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .fast_charge_current_dma(cur), .fast_charge_current_wr(fcc_wr),
        .input_regulator_active(lv[6]), .system_voltage_ok(lv[5]),
        .battery_side_node_ok(lv[4]), .battery_weak(lv[3]), .charging_enabled(lv[2]),
        .input_supply_zero(lv[1]), .battery_monitor_enable(lv[0]),
        .termination_threshold_dma(thr), .threshold_valid(thr_valid),
        .system_enable_output(se), .isolation_switch_disable(iso));
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    function automatic logic [15:0] exp_thr(input logic [7:0] c, input logic [15:0] i);
        int v;
        if (c[4]) v = i / 20;
        else if (c[3]) v = i / 10;
        else if (c[2]) v = i / 5;
        else return CODE_T[c[7:5]];
        if (v < 125) v = 125;
        if (v > 1700) v = 1700;
        return v[15:0];
    endfunction : exp_thr
    // Returns isolation disable and system enable
    function automatic logic [1:0] exp_se(input logic [1:0] m, input logic [6:0] l);
        case (m)
            2'b00: return {1'b0, l[6] & l[5]};
            2'b01: return {1'b0, l[4]};
            2'b10: return (l[1] & l[0]) ? {l[3], l[3]} : {1'b0, l[6] & l[5]};
            default: return {1'b0, l[2] ? l[4] : l[6]};
        endcase
    endfunction : exp_se
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic step2();
        repeat (2) @(posedge core_clk);
        #1;
    endtask : step2
    // One write of the control register followed by a current update
    task automatic run_case(input logic [7:0] c, input logic [15:0] i, input logic [15:0] i2);
        @(posedge core_clk);
        #1;
        cur = i;
        lv = rnd[14:8];
        u_host.wr(8'h11, c);
        step2();
        chk(thr, exp_thr(c, i));
        chk({15'h0, thr_valid}, 16'h1);
        chk({14'h0, iso, se}, {14'h0, exp_se(c[1:0], lv)});
        u_host.rd(8'h11, rdv);
        chk({8'h0, rdv}, {8'h0, c});
        cur = i2;
        fcc_wr = 1'b1;
        @(posedge core_clk);
        #1;
        fcc_wr = 1'b0;
        chk({15'h0, thr_valid}, 16'h0);
        step2();
        chk(thr, exp_thr(c, i2));
    endtask : run_case
    initial
    begin
        repeat (2) @(posedge core_clk);
        #1;
        rst = 1'b0;
        chk({8'h0, reg_rdata}, 16'h0000);
        lv = 7'h60;
        step2();
        chk(thr, 16'h020d);
        chk({14'h0, iso, se}, 16'h0001);
        u_host.rd(8'h11, rdv);
        chk({8'h0, rdv}, 16'h0040);
        u_host.wr(8'h12, 8'hff);
        u_host.rd(8'h12, rdv);
        chk({8'h0, rdv}, 16'h0000);
        u_host.rd(8'h11, rdv);
        chk({8'h0, rdv}, 16'h0040);
        run_case(8'h1c, 16'd2500, 16'd34000);
        run_case(8'h0e, 16'd1249, 16'd17010);
        run_case(8'h05, 16'hffff, 16'd0);
        run_case(8'h02, 16'd0, 16'd900);
        for (int k = 0; k < 64; k++)
        begin
            rnd = xs(rnd);
            run_case(rnd[7:0], {4'h0, rnd[27:16]}, {3'h0, rnd[31:19]});
        end
        rst = 1'b1;
        @(posedge core_clk);
        #1;
        rst = 1'b0;
        step2();
        chk(thr, 16'h020d);
        u_host.rd(8'h11, rdv);
        chk({8'h0, rdv}, 16'h0040);
        print_verdict();
    end
    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end
endmodule : tb
